/* File: bench/nested_vectored_irq_controller_checker.sv */
/* nested_vectored_irq_controller_checker: port assertions for nested_vectored_irq_controller_top.
 assumes bind to nested_vectored_irq_controller_top, one clock, rst_n low-active sync. */
`timescale 1ns/100ps
module nested_vectored_irq_controller_checker
	import nested_vectored_irq_controller_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire nested_vectored_irq_controller_bus_t bus,
	input wire logic [31:0] rdata,
	input wire logic take_ack,
	input wire nested_vectored_irq_controller_take_t take,
	input wire logic [31:0] sp_fetch_addr
);
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	chk_fetch_addr: assert property (take.req |-> take.fetch_addr == {24'h0, take.vec, 2'b00})
		else $error("fetch address off");
	chk_vec_range: assert property (take.req |-> take.vec inside {[6'h10:6'h2f]})
		else $error("vector out of range");
	chk_line_map: assert property (take.req |-> NESTED_VECTORED_IRQ_CONTROLLER_LINE_MAP[{~take.vec[4], take.vec[3:0]}])
		else $error("reserved line offered");
	chk_sp_word: assert property (sp_fetch_addr == NESTED_VECTORED_IRQ_CONTROLLER_VTOR_BASE)
		else $error("stack word address off");
	// offer must not shift under the core
	chk_offer_hold: assert property (take.req && $past(take.req) |-> $stable(take.fetch_addr))
		else $error("offer changed while standing");
	chk_ack_drop: assert property (take.req && take_ack |=> !take.req)
		else $error("offer stayed after accept");
	// read data only after a read
	chk_rd_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data outside its cycle");
	chk_clr_stop: assert property (bus.wr && bus.addr == NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_EN
		&& bus.wdata == 32'hffff_ffff |=> ##1 !take.req)
		else $error("offer on disabled line");
endmodule

bind nested_vectored_irq_controller_top nested_vectored_irq_controller_checker chk_u (.mclk, .rst_n, .bus, .rdata, .take_ack, .take, .sp_fetch_addr);

/* File: bench/nested_vectored_irq_controller_core_model.sv */
/* nested_vectored_irq_controller_core_model: core side, accepts offers after ack_dly cycles.
 assumes offers drop the cycle after take_ack. */
`timescale 1ns/100ps
module nested_vectored_irq_controller_core_model
	import nested_vectored_irq_controller_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire nested_vectored_irq_controller_take_t take,
	input wire logic [3:0] ack_dly,
	output logic take_ack,
	output logic [5:0] got_vec
);
	logic [3:0] wait_cnt;

	// one-cycle accept; holds off while the offer falls
	always_ff @(posedge mclk)
	begin
		if (!rst_n || !take.req || take_ack)
		begin
			take_ack <= 1'b0;
			wait_cnt <= 4'h0;
		end
		else if (wait_cnt == ack_dly)
		begin
			take_ack <= 1'b1;
			got_vec <= take.vec;
		end
		else
			wait_cnt <= wait_cnt + 4'h1;
	end
endmodule

/* File: bench/tb_nested_vectored_irq_controller.sv */
/* tb_nested_vectored_irq_controller: directed bench for nested_vectored_irq_controller_top.
 assumes nested_vectored_irq_controller_core_model as core and the bound checker. */
`timescale 1ns/100ps
module tb_nested_vectored_irq_controller
	import nested_vectored_irq_controller_pkg::*;
();
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] irq_in = 32'h0;
	logic [2:0] src = 3'h0;
	logic exc_return = 1'b0;
	logic [3:0] ack_dly = 4'h0;
	nested_vectored_irq_controller_bus_t bus = '0;
	logic [31:0] rdata;
	logic [31:0] sp_fetch_addr;
	logic take_ack;
	logic irq_out;
	logic [5:0] got_vec;
	nested_vectored_irq_controller_take_t take;
	int errors = 0;
	int num_checks = 0;

	initial
		forever #10 mclk = ~mclk;

	nested_vectored_irq_controller_top dut_u (.mclk, .rst_n, .irq_in, .usb_irq(src[0]), .power_wake_irq(src[1]),
		.rtc_irq(src[2]), .bus, .rdata, .take_ack, .exc_return, .take, .sp_fetch_addr, .irq_out);
	nested_vectored_irq_controller_core_model core_u (.mclk, .rst_n, .take, .ack_dly, .take_ack, .got_vec);

	task automatic end_of_test();
		if (errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask

	// read data stands the cycle after the strobe
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		@(posedge mclk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask

	task automatic ret();
		@(posedge mclk);
		exc_return <= 1'b1;
		@(posedge mclk);
		exc_return <= 1'b0;
	endtask

	// bounded wait on the offer level
	task automatic wait_req(input logic want);
		int n;
		n = 0;
		while (take.req !== want)
		begin
			idle(1);
			n++;
			if (n > 40)
			begin
				errors++;
				end_of_test();
			end
		end
	endtask

	task automatic take_one(input logic [5:0] v);
		wait_req(1'b1);
		chk({26'h0, take.vec}, {26'h0, v});
		chk(take.fetch_addr, {24'h0, v, 2'b00});
		wait_req(1'b0);
		chk({26'h0, got_vec}, {26'h0, v});
	endtask

	task automatic t_reset();
		rd(NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_EN, 32'h0);
		rd(NESTED_VECTORED_IRQ_CONTROLLER_REG_PRIO7, 32'h0);
		chk(sp_fetch_addr, NESTED_VECTORED_IRQ_CONTROLLER_VTOR_BASE);
	endtask

	task automatic t_enable();
		wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_EN, 32'h8000_0005);
		wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_EN, 32'h0);
		rd(NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_EN, 32'h8000_0005);
		wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_EN, 32'h8000_0001);
		rd(NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_EN, 32'h0000_0004);
		wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_EN, 32'hffff_ffff);
	endtask

	// disabled usb line and reserved bit 7
	task automatic t_pend();
		src <= 3'h1;
		irq_in <= 32'h0000_1080;
		wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_PEND, 32'h0000_0084);
		src <= 3'h0;
		irq_in <= 32'h0;
		rd(NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_PEND, 32'h0080_0004);
		chk({31'h0, take.req}, 32'h0);
		wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_PEND, 32'h0080_0004);
		rd(NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_PEND, 32'h0);
	endtask

	task automatic t_route();
		logic [4:0] ln [3] = '{NESTED_VECTORED_IRQ_CONTROLLER_LINE_USB, NESTED_VECTORED_IRQ_CONTROLLER_LINE_WAKE, NESTED_VECTORED_IRQ_CONTROLLER_LINE_RTC};
		for (int i = 0; i < 3; i++)
		begin
			ack_dly <= 4'(2 * i);
			wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_EN, 32'h1 << ln[i]);
			src <= 3'h1 << i;
			take_one(6'h10 + ln[i]);
			src <= 3'h0;
			wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_EN, 32'hffff_ffff);
			wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_PEND, 32'hffff_ffff);
			rd(NESTED_VECTORED_IRQ_CONTROLLER_REG_ACTIVE, 32'h1 << ln[i]);
			ret();
			rd(NESTED_VECTORED_IRQ_CONTROLLER_REG_ACTIVE, 32'h0);
		end
	endtask

	// lines 0,1 at level 2, line 2 at level 1
	task automatic t_preempt();
		wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_PRIO0, 32'h0040_8080);
		rd(NESTED_VECTORED_IRQ_CONTROLLER_REG_PRIO0, 32'h0040_8080);
		wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_EN, 32'h7);
		irq_in <= 32'h1;
		take_one(6'h10);
		irq_in <= 32'h3;
		idle(4);
		chk({31'h0, take.req}, 32'h0);
		irq_in <= 32'h7;
		take_one(6'h12);
		ret();
		idle(4);
		chk({31'h0, take.req}, 32'h0);
		ret();
		take_one(6'h11);
		ret();
		irq_in <= 32'h0;
	endtask

	task automatic t_event();
		rd(NESTED_VECTORED_IRQ_CONTROLLER_REG_EVT_STAT, 32'h3);
		chk({31'h0, irq_out}, 32'h0);
		wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_EVT_EN, 32'h2);
		idle(1);
		chk({31'h0, irq_out}, 32'h1);
		wr(NESTED_VECTORED_IRQ_CONTROLLER_REG_EVT_CLR, 32'h2);
		idle(1);
		chk({31'h0, irq_out}, 32'h0);
		rd(NESTED_VECTORED_IRQ_CONTROLLER_REG_EVT_STAT, 32'h1);
		rd(6'h05, 32'h0);
	endtask

	initial
	begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_enable();
		t_pend();
		t_route();
		t_preempt();
		t_event();
		end_of_test();
	end
endmodule

/* File: logic/nested_vectored_irq_controller_pkg.sv */
/*
 * nested_vectored_irq_controller_pkg: constants and types shared by the interrupt controller.
 * Assumes a 32-bit register port on the core clock, word-indexed offsets.
 */
package nested_vectored_irq_controller_pkg;
	localparam int unsigned NESTED_VECTORED_IRQ_CONTROLLER_LINES = 32;
	localparam int unsigned NESTED_VECTORED_IRQ_CONTROLLER_PRIO_W = 2;
	localparam int unsigned NESTED_VECTORED_IRQ_CONTROLLER_FIELD_W = 8;
	localparam int unsigned NESTED_VECTORED_IRQ_CONTROLLER_VEC_W = 6;
	localparam int unsigned NESTED_VECTORED_IRQ_CONTROLLER_ADDR_W = 6;

	// vector numbering
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_VEC_IRQ_BASE = 6'h10;
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_VEC_SP_INIT = 6'h00;
	localparam logic [31:0] NESTED_VECTORED_IRQ_CONTROLLER_VTOR_BASE = 32'h0000_0000;
	localparam logic [4:0] NESTED_VECTORED_IRQ_CONTROLLER_LINE_USB = 5'h17;
	localparam logic [4:0] NESTED_VECTORED_IRQ_CONTROLLER_LINE_WAKE = 5'h1c;
	localparam logic [4:0] NESTED_VECTORED_IRQ_CONTROLLER_LINE_RTC = 5'h1f;

	// lines with a source behind them; reserved lines stay zero
	localparam logic [31:0] NESTED_VECTORED_IRQ_CONTROLLER_LINE_MAP = 32'h9188_ef7f;

	// priority: 0 highest, 3 lowest
	localparam logic [1:0] NESTED_VECTORED_IRQ_CONTROLLER_PRIO_RESET = 2'h0;
	localparam logic [2:0] NESTED_VECTORED_IRQ_CONTROLLER_PRIO_IDLE = 3'h4;

	// register word offsets (byte address = 4 * index)
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_EN = 6'h00;
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_EN = 6'h01;
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_PEND = 6'h02;
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_PEND = 6'h03;
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_REG_ACTIVE = 6'h04;
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_REG_PRIO0 = 6'h08;
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_REG_PRIO7 = 6'h0f;
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_REG_EVT_STAT = 6'h10;
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_REG_EVT_CLR = 6'h11;
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_REG_EVT_EN = 6'h12;
	localparam logic [5:0] NESTED_VECTORED_IRQ_CONTROLLER_REG_CORE = 6'h13;

	// event status bits
	localparam int unsigned NESTED_VECTORED_IRQ_CONTROLLER_EVT_W = 2;
	localparam int unsigned NESTED_VECTORED_IRQ_CONTROLLER_EVT_TAKE = 0;
	localparam int unsigned NESTED_VECTORED_IRQ_CONTROLLER_EVT_PREEMPT = 1;

	typedef struct packed {
		logic [NESTED_VECTORED_IRQ_CONTROLLER_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} nested_vectored_irq_controller_bus_t;

	typedef struct packed {
		logic req;
		logic [NESTED_VECTORED_IRQ_CONTROLLER_VEC_W-1:0] vec;
		logic [31:0] fetch_addr;
	} nested_vectored_irq_controller_take_t;

	typedef enum logic [1:0] {
		NESTED_VECTORED_IRQ_CONTROLLER_IDLE,
		NESTED_VECTORED_IRQ_CONTROLLER_OFFER
	} nested_vectored_irq_controller_state_t;
endpackage

/* File: logic/nested_vectored_irq_controller_top.sv */
/*
 * nested_vectored_irq_controller_top: vectored interrupt controller for the core.
 * Holds enable, pending, active and priority state per line, picks the
 * best pending line, offers it to the core with its vector fetch address
 * and tracks nesting through accept and exception-return pulses.
 * Assumes peripheral lines are level requests synchronous to mclk and
 * the core pulses take_ack and exc_return one cycle each.
 */
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
module nested_vectored_irq_controller_top
	import nested_vectored_irq_controller_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [NESTED_VECTORED_IRQ_CONTROLLER_LINES-1:0] irq_in,
	input wire logic usb_irq,
	input wire logic power_wake_irq,
	input wire logic rtc_irq,
	input wire nested_vectored_irq_controller_bus_t bus,
	output logic [31:0] rdata,
	input wire logic take_ack,
	input wire logic exc_return,
	output nested_vectored_irq_controller_take_t take,
	output logic [31:0] sp_fetch_addr,
	output logic irq_out
);
	logic [NESTED_VECTORED_IRQ_CONTROLLER_LINES-1:0] enable;
	logic [NESTED_VECTORED_IRQ_CONTROLLER_LINES-1:0] pending;
	logic [NESTED_VECTORED_IRQ_CONTROLLER_LINES-1:0] active;
	logic [NESTED_VECTORED_IRQ_CONTROLLER_LINES-1:0] src;
	logic [NESTED_VECTORED_IRQ_CONTROLLER_LINES-1:0] src_d;
	logic [NESTED_VECTORED_IRQ_CONTROLLER_PRIO_W-1:0] prio [NESTED_VECTORED_IRQ_CONTROLLER_LINES];
	logic [NESTED_VECTORED_IRQ_CONTROLLER_EVT_W-1:0] evt_stat;
	logic [NESTED_VECTORED_IRQ_CONTROLLER_EVT_W-1:0] evt_en;
	logic [4:0] cur_line;
	logic [2:0] run_prio;
	nested_vectored_irq_controller_state_t state;
	logic best_ok;
	logic [4:0] best_line;
	logic [2:0] best_prio;
	logic wr_en;
	logic wr_pend;
	logic [4:0] pick_line;
	logic [2:0] pick_prio;
	logic [4:0] offer_line;

	// wire dedicated peripheral requests onto their lines
	always_comb
	begin
		src = irq_in;
		src[NESTED_VECTORED_IRQ_CONTROLLER_LINE_USB] = usb_irq;
		src[NESTED_VECTORED_IRQ_CONTROLLER_LINE_WAKE] = power_wake_irq;
		src[NESTED_VECTORED_IRQ_CONTROLLER_LINE_RTC] = rtc_irq;
		src = src & NESTED_VECTORED_IRQ_CONTROLLER_LINE_MAP;
	end

	// request edge detect; a held level pends only once
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			src_d <= '0;
		else
			src_d <= src;
	end

	assign wr_en = bus.wr && (bus.addr == NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_EN || bus.addr == NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_EN);
	assign wr_pend = bus.wr && (bus.addr == NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_PEND || bus.addr == NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_PEND);

	// line behind the standing offer; low vector bits alone are not the line
	assign offer_line = 5'(take.vec - NESTED_VECTORED_IRQ_CONTROLLER_VEC_IRQ_BASE);

	// enable state
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			enable <= '0;
		else if (wr_en && bus.addr == NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_EN)
			enable <= enable | bus.wdata;
		else if (wr_en)
			enable <= enable & ~bus.wdata;
	end

	// best pending enabled line; lowest number wins a tie
	always_comb
	begin
		best_ok = 1'b0;
		best_line = '0;
		best_prio = NESTED_VECTORED_IRQ_CONTROLLER_PRIO_IDLE;
		for (int i = NESTED_VECTORED_IRQ_CONTROLLER_LINES - 1; i >= 0; i--)
		begin
			if (pending[i] && enable[i] && !active[i] && {1'b0, prio[i]} <= best_prio)
			begin
				best_ok = 1'b1;
				best_line = 5'(i);
				best_prio = {1'b0, prio[i]};
			end
		end
	end

	// highest-priority line still active, restored after a return
	always_comb
	begin
		pick_line = '0;
		pick_prio = NESTED_VECTORED_IRQ_CONTROLLER_PRIO_IDLE;
		for (int i = NESTED_VECTORED_IRQ_CONTROLLER_LINES - 1; i >= 0; i--)
		begin
			if (active[i] && !(exc_return && 5'(i) == cur_line)
				&& {1'b0, prio[i]} <= pick_prio)
			begin
				pick_line = 5'(i);
				pick_prio = {1'b0, prio[i]};
			end
		end
	end

	// pending state: hardware edges and set win over a clear write
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pending <= '0;
		else
		begin
			pending <= ((wr_pend && bus.addr == NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_PEND) ? pending & ~bus.wdata
				: pending)
				| ((wr_pend && bus.addr == NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_PEND) ? bus.wdata & NESTED_VECTORED_IRQ_CONTROLLER_LINE_MAP : '0)
				| (src & ~src_d);
			// a fresh edge on the accepted line keeps it pending: set wins
			if (state == NESTED_VECTORED_IRQ_CONTROLLER_OFFER && take_ack && !(src[offer_line] && !src_d[offer_line]))
				pending[offer_line] <= 1'b0;
		end
	end

	// active state and nesting
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			active <= '0;
			cur_line <= '0;
			run_prio <= NESTED_VECTORED_IRQ_CONTROLLER_PRIO_IDLE;
		end
		else if (state == NESTED_VECTORED_IRQ_CONTROLLER_OFFER && take_ack)
		begin
			active[offer_line] <= 1'b1;
			cur_line <= offer_line;
			run_prio <= {1'b0, prio[offer_line]};
		end
		else if (exc_return && active[cur_line])
		begin
			active[cur_line] <= 1'b0;
			cur_line <= pick_line;
			run_prio <= pick_prio;
		end
	end

	// priority fields, four lines per word
	generate
		for (genvar g = 0; g < NESTED_VECTORED_IRQ_CONTROLLER_LINES; g++)
		begin : g_prio
			always_ff @(posedge mclk)
			begin
				if (!rst_n)
					prio[g] <= NESTED_VECTORED_IRQ_CONTROLLER_PRIO_RESET;
				else if (bus.wr && bus.addr == NESTED_VECTORED_IRQ_CONTROLLER_REG_PRIO0 + 6'(g / 4))
					// top two bits of the field
					prio[g] <= bus.wdata[(g % 4) * NESTED_VECTORED_IRQ_CONTROLLER_FIELD_W + NESTED_VECTORED_IRQ_CONTROLLER_FIELD_W - 1 -: NESTED_VECTORED_IRQ_CONTROLLER_PRIO_W];
			end
		end
	endgenerate

	// offer to core; entry held steady until accepted
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state <= NESTED_VECTORED_IRQ_CONTROLLER_IDLE;
			take <= '0;
		end
		else
		begin
			unique case (state)
				NESTED_VECTORED_IRQ_CONTROLLER_IDLE:
					if (best_ok && best_prio < run_prio)
					begin
						state <= NESTED_VECTORED_IRQ_CONTROLLER_OFFER;
						take.req <= 1'b1;
						take.vec <= NESTED_VECTORED_IRQ_CONTROLLER_VEC_IRQ_BASE + {1'b0, best_line};
						take.fetch_addr <= NESTED_VECTORED_IRQ_CONTROLLER_VTOR_BASE
							+ {24'h00_0000, (NESTED_VECTORED_IRQ_CONTROLLER_VEC_IRQ_BASE + {1'b0, best_line}), 2'b00};
					end
				NESTED_VECTORED_IRQ_CONTROLLER_OFFER:
					if (take_ack)
					begin
						state <= NESTED_VECTORED_IRQ_CONTROLLER_IDLE;
						take.req <= 1'b0;
					end
					// withdraw if software removed it before acceptance
					else if (!pending[offer_line] || !enable[offer_line])
					begin
						state <= NESTED_VECTORED_IRQ_CONTROLLER_IDLE;
						take.req <= 1'b0;
					end
			endcase
		end
	end

	// stack pointer word at offset zero
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			sp_fetch_addr <= NESTED_VECTORED_IRQ_CONTROLLER_VTOR_BASE + {24'h00_0000, NESTED_VECTORED_IRQ_CONTROLLER_VEC_SP_INIT, 2'b00};
	end

	// sticky event status, cleared by writing ones; set wins
	// bit 1 marks a take that nests over a running handler
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			evt_stat <= '0;
			evt_en <= '0;
		end
		else
		begin
			evt_stat <= (evt_stat & ~((bus.wr && bus.addr == NESTED_VECTORED_IRQ_CONTROLLER_REG_EVT_CLR)
				? bus.wdata[NESTED_VECTORED_IRQ_CONTROLLER_EVT_W-1:0] : '0))
				| {(state == NESTED_VECTORED_IRQ_CONTROLLER_OFFER && take_ack && cur_line != offer_line
					&& run_prio != NESTED_VECTORED_IRQ_CONTROLLER_PRIO_IDLE),
					(state == NESTED_VECTORED_IRQ_CONTROLLER_OFFER && take_ack)};
			if (bus.wr && bus.addr == NESTED_VECTORED_IRQ_CONTROLLER_REG_EVT_EN)
				evt_en <= bus.wdata[NESTED_VECTORED_IRQ_CONTROLLER_EVT_W-1:0];
		end
	end

	// interrupt output registered
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq_out <= 1'b0;
		else
			irq_out <= |(evt_stat & evt_en);
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rdata <= '0;
		else if (!bus.rd)
			rdata <= '0;
		else if (bus.addr >= NESTED_VECTORED_IRQ_CONTROLLER_REG_PRIO0 && bus.addr <= NESTED_VECTORED_IRQ_CONTROLLER_REG_PRIO7)
			for (int k = 0; k < 4; k++)
				rdata[k*NESTED_VECTORED_IRQ_CONTROLLER_FIELD_W +: NESTED_VECTORED_IRQ_CONTROLLER_FIELD_W] <=
					{prio[{bus.addr[2:0], 2'(k)}], 6'h00};
		else
		begin
			unique case (bus.addr)
				NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_EN, NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_EN: rdata <= enable;
				NESTED_VECTORED_IRQ_CONTROLLER_REG_SET_PEND, NESTED_VECTORED_IRQ_CONTROLLER_REG_CLR_PEND: rdata <= pending;
				NESTED_VECTORED_IRQ_CONTROLLER_REG_ACTIVE: rdata <= active;
				NESTED_VECTORED_IRQ_CONTROLLER_REG_EVT_STAT: rdata <= {30'h0000_0000, evt_stat};
				NESTED_VECTORED_IRQ_CONTROLLER_REG_EVT_EN: rdata <= {30'h0000_0000, evt_en};
				NESTED_VECTORED_IRQ_CONTROLLER_REG_CORE: rdata <= {26'h000_0000, run_prio == NESTED_VECTORED_IRQ_CONTROLLER_PRIO_IDLE, cur_line};
				default: rdata <= '0;
			endcase
		end
	end
endmodule
